// ### design/tsr_bank.sv
// Security, ring oscillator, RAM size and saved status register bank
`timescale 1ns/10ps
`include "tsr_cfg.svh"

module tsr_bank #(
   parameter int          OSC_W     = 16,
   parameter int          NUM_OSC   = 4,
   parameter logic [31:0] RAM_BYTES = 32'h0010_0000
) (
   input  wire logic               ref_clk,
   input  wire logic               resetn,
   input  wire tsr_pkg::tsr_req_s  ps_req,
   output logic [31:0]             ps_rdata,
   output logic                    ps_ack,
   output logic                    ps_write_refused,
   input  wire logic               otp_word_valid,
   input  wire logic [31:0]        otp_security_word,
   input  wire logic               debug_enter,
   input  wire tsr_pkg::tsr_status_s thread_status,
   input  wire logic [NUM_OSC-1:0] osc_clk,
   output logic                    core_osc_enable,
   output logic                    periph_osc_enable,
   output tsr_pkg::tsr_sec_s       sec_ctrl,
   output logic                    osc_stable
);

   initial begin
      if (OSC_W != 16 || NUM_OSC != 4) begin
         $error("Oscillator layout must be four 16-bit counters");
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Security word load and lock

   logic [31:0]       sec_r;
   tsr_pkg::tsr_load_e load_r;
   logic               wr_sec;
   logic               wr_osc;
   logic               wr_ssr;

   assign wr_sec = ps_req.valid && ps_req.write && ps_req.num == `TSR_ADDR_SECURITY;
   assign wr_osc = ps_req.valid && ps_req.write && ps_req.num == `TSR_ADDR_OSC_CTRL;
   assign wr_ssr = ps_req.valid && ps_req.write && ps_req.num == `TSR_ADDR_SAVED_STATUS;

   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         load_r <= tsr_pkg::TSR_LOAD_IDLE;
      end else begin
         case (load_r)
            tsr_pkg::TSR_LOAD_IDLE: begin
               if (otp_word_valid) begin
                  load_r <= tsr_pkg::TSR_LOAD_DONE;
               end
            end
            tsr_pkg::TSR_LOAD_DONE: load_r <= tsr_pkg::TSR_LOAD_DONE;
            default:                load_r <= tsr_pkg::TSR_LOAD_IDLE;
         endcase
      end
   end

   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         sec_r <= 32'h0000_0000;
      end else if (load_r == tsr_pkg::TSR_LOAD_IDLE && otp_word_valid) begin
         sec_r <= otp_security_word & `TSR_SEC_WRITE_MASK;
      end else if (wr_sec && !sec_r[`TSR_SEC_LOCK_BIT]) begin
         sec_r <= ps_req.wdata & `TSR_SEC_WRITE_MASK;
      end
   end

   assign ps_write_refused = wr_sec && sec_r[`TSR_SEC_LOCK_BIT];

   always_comb begin
      sec_ctrl.no_global_debug        = sec_r[`TSR_SEC_NO_GDEBUG_BIT];
      sec_ctrl.otp_read_lock          = sec_r[`TSR_SEC_OTP_RDLOCK_BIT];
      sec_ctrl.otp_program_block      = sec_r[`TSR_SEC_OTP_PROG_BIT];
      sec_ctrl.otp_merge_space        = sec_r[`TSR_SEC_OTP_MERGE_BIT];
      sec_ctrl.boot_from_otp_override = sec_r[`TSR_SEC_OTP_BOOT_BIT];
      sec_ctrl.pll_jtag_block         = sec_r[`TSR_SEC_PLL_JTAG_BIT];
      sec_ctrl.jtag_tap_block         = sec_r[`TSR_SEC_JTAG_TAP_BIT];
   end

   ////////////////////////////////////////////////////////////////////////////
   // Oscillator control

   logic [1:0] osc_ctrl_r;
   logic [3:0] stop_cnt_r;

   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         osc_ctrl_r <= `TSR_OSC_CTRL_RESET;
      end else if (wr_osc) begin
         osc_ctrl_r <= ps_req.wdata[1:0];
      end
   end

   assign core_osc_enable   = osc_ctrl_r[`TSR_OSC_CORE_BIT];
   assign periph_osc_enable = osc_ctrl_r[`TSR_OSC_PERI_BIT];

   // Counts tile cycles since both oscillators stopped
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         stop_cnt_r <= 4'h0;
      end else if (osc_ctrl_r != 2'h0) begin
         stop_cnt_r <= 4'h0;
      end else if (stop_cnt_r != 4'(`TSR_OSC_STOP_CYCLES)) begin
         stop_cnt_r <= stop_cnt_r + 4'h1;
      end
   end

   assign osc_stable = stop_cnt_r == 4'(`TSR_OSC_STOP_CYCLES);

   ////////////////////////////////////////////////////////////////////////////
   // Free-running counters, one per oscillator domain

   logic [OSC_W-1:0] osc_cnt [NUM_OSC];
   logic [NUM_OSC-1:0] osc_en;

   assign osc_en = {periph_osc_enable, periph_osc_enable, core_osc_enable, core_osc_enable};

   genvar gi;
   generate
      for (gi = 0; gi < NUM_OSC; gi++) begin : g_osc
         // Power-up value only; reset never touches these
         logic [2:0]       en_sync_r = 3'h0;
         logic [OSC_W-1:0] cnt_r     = '0;
         // Enable crosses into the oscillator domain; no reset so count survives
         always_ff @(posedge osc_clk[gi]) begin
            en_sync_r <= {en_sync_r[1:0], osc_en[gi]};
         end
         always_ff @(posedge osc_clk[gi]) begin
            if (en_sync_r[2] && en_sync_r[1]) begin
               cnt_r <= cnt_r + 16'h0001;
            end
         end
         assign osc_cnt[gi] = cnt_r;
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////
   // Saved thread status

   logic [31:0] ssr_r;
   logic [31:0] status_word;

   assign status_word = 32'(thread_status[9:5]) << 6 | 32'(thread_status[4:0]);

   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         ssr_r <= 32'h0000_0000;
      end else if (debug_enter) begin
         ssr_r <= status_word & `TSR_SSR_MASK;
      end else if (wr_ssr) begin
         ssr_r <= (ps_req.wdata & `TSR_SSR_WRITE_MASK) | (ssr_r & 32'h0000_0100);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Status read port

   logic [31:0] rdata_nxt;

   always_comb begin
      rdata_nxt = 32'h0000_0000;
      case (ps_req.num)
         `TSR_ADDR_SECURITY:     rdata_nxt = sec_r;
         `TSR_ADDR_OSC_CTRL:     rdata_nxt = {30'h0, osc_ctrl_r};
         `TSR_ADDR_CORE_CELL:    rdata_nxt = {16'h0, osc_cnt[0]};
         `TSR_ADDR_CORE_WIRE:    rdata_nxt = {16'h0, osc_cnt[1]};
         `TSR_ADDR_PERI_CELL:    rdata_nxt = {16'h0, osc_cnt[2]};
         `TSR_ADDR_PERI_WIRE:    rdata_nxt = {16'h0, osc_cnt[3]};
         `TSR_ADDR_RAM_SIZE:     rdata_nxt = RAM_BYTES & `TSR_RAM_SIZE_MASK;
         `TSR_ADDR_SAVED_STATUS: rdata_nxt = ssr_r;
         default:                rdata_nxt = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         ps_rdata <= 32'h0000_0000;
         ps_ack   <= 1'b0;
      end else begin
         ps_ack <= ps_req.valid;
         if (ps_req.valid && !ps_req.write) begin
            ps_rdata <= rdata_nxt;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Assertions

   a_sec_lock_hold: assert property (@(posedge ref_clk) disable iff (!resetn)
      sec_r[31] && load_r == tsr_pkg::TSR_LOAD_DONE |=> $stable(sec_r))
      else $error("Locked security word changed");

   a_sec_write_take: assert property (@(posedge ref_clk) disable iff (!resetn)
      wr_sec && !sec_r[31] && load_r == tsr_pkg::TSR_LOAD_DONE |=> sec_r == ($past(ps_req.wdata) & 32'h8000_47b1))
      else $error("Unlocked security write not taken");

   a_sec_otp_load: assert property (@(posedge ref_clk) disable iff (!resetn)
      load_r == tsr_pkg::TSR_LOAD_IDLE && otp_word_valid |=> sec_r == ($past(otp_security_word) & 32'h8000_47b1))
      else $error("OTP security word not loaded");

   a_sec_tap_out: assert property (@(posedge ref_clk) disable iff (!resetn)
      sec_ctrl.jtag_tap_block == sec_r[0] && sec_ctrl.no_global_debug == sec_r[14])
      else $error("Security outputs mismatch");

   a_osc_ctrl_wr: assert property (@(posedge ref_clk) disable iff (!resetn)
      wr_osc |=> core_osc_enable == $past(ps_req.wdata[1]) && periph_osc_enable == $past(ps_req.wdata[0]))
      else $error("Oscillator enables not updated");

   a_osc_stable_ten: assert property (@(posedge ref_clk) disable iff (!resetn)
      osc_ctrl_r != 2'h0 ##1 (osc_ctrl_r == 2'h0 && !wr_osc) [*8] |-> !osc_stable)
      else $error("Stable flagged too early");

   a_ssr_capture: assert property (@(posedge ref_clk) disable iff (!resetn)
      debug_enter |=> ssr_r[4:0] == $past(thread_status[4:0]) && ssr_r[10:6] == $past(thread_status[9:5]))
      else $error("Status not captured on debug entry");

   a_ssr_reserved: assert property (@(posedge ref_clk) disable iff (!resetn)
      ssr_r[5] == 1'b0 && ssr_r[31:11] == 21'h0)
      else $error("Reserved status bits set");

   a_read_ram: assert property (@(posedge ref_clk) disable iff (!resetn)
      ps_req.valid && !ps_req.write && ps_req.num == 8'h0c |=> ps_ack && ps_rdata[1:0] == 2'h0)
      else $error("RAM size read wrong");

   a_read_cnt_hi: assert property (@(posedge ref_clk) disable iff (!resetn)
      ps_req.valid && !ps_req.write && ps_req.num == 8'h07 |=> ps_rdata[31:16] == 16'h0)
      else $error("Counter upper bits not zero");

   a_sec_gdebug_out: assert property (@(posedge ref_clk) disable iff (!resetn)
      sec_ctrl.no_global_debug == sec_r[14])
      else $error("Global debug block output wrong");

   a_sec_rdlock_out: assert property (@(posedge ref_clk) disable iff (!resetn)
      sec_ctrl.otp_read_lock == sec_r[9])
      else $error("OTP read lock output wrong");

   a_sec_prog_out: assert property (@(posedge ref_clk) disable iff (!resetn)
      sec_ctrl.otp_program_block == sec_r[8])
      else $error("OTP program block output wrong");

   a_sec_merge_out: assert property (@(posedge ref_clk) disable iff (!resetn)
      sec_ctrl.otp_merge_space == sec_r[7])
      else $error("OTP merge output wrong");

   a_sec_boot_out: assert property (@(posedge ref_clk) disable iff (!resetn)
      sec_ctrl.boot_from_otp_override == sec_r[5])
      else $error("Boot override output wrong");

   a_sec_pll_out: assert property (@(posedge ref_clk) disable iff (!resetn)
      sec_ctrl.pll_jtag_block == sec_r[4])
      else $error("PLL access block output wrong");

   a_sec_lock_refuse: assert property (@(posedge ref_clk) disable iff (!resetn)
      wr_sec && sec_r[31] |-> ps_write_refused)
      else $error("Locked write not refused");

   a_sec_refuse_only: assert property (@(posedge ref_clk) disable iff (!resetn)
      ps_write_refused |-> wr_sec && sec_r[31])
      else $error("Refusal without locked write");

   a_sec_reserved_zero: assert property (@(posedge ref_clk) disable iff (!resetn)
      (sec_r & ~`TSR_SEC_WRITE_MASK) == 32'h0000_0000)
      else $error("Reserved security bits set");

   a_load_once: assert property (@(posedge ref_clk) disable iff (!resetn)
      load_r == tsr_pkg::TSR_LOAD_DONE |=> load_r == tsr_pkg::TSR_LOAD_DONE)
      else $error("Security load repeated");

   a_osc_ctrl_hold: assert property (@(posedge ref_clk) disable iff (!resetn)
      !wr_osc |=> $stable(osc_ctrl_r))
      else $error("Oscillator control changed without write");

   a_osc_core_en: assert property (@(posedge ref_clk) disable iff (!resetn)
      core_osc_enable == osc_ctrl_r[1])
      else $error("Core oscillator enable wrong");

   a_osc_peri_en: assert property (@(posedge ref_clk) disable iff (!resetn)
      periph_osc_enable == osc_ctrl_r[0])
      else $error("Peripheral oscillator enable wrong");

   a_osc_stable_clear: assert property (@(posedge ref_clk) disable iff (!resetn)
      osc_ctrl_r != 2'h0 |=> !osc_stable)
      else $error("Stable while oscillators run");

   a_osc_stable_set: assert property (@(posedge ref_clk) disable iff (!resetn)
      osc_ctrl_r == 2'h0 && stop_cnt_r == 4'h9 |=> osc_stable)
      else $error("Stable not flagged after ten cycles");

   a_ack_pulse: assert property (@(posedge ref_clk) disable iff (!resetn)
      ps_req.valid |=> ps_ack)
      else $error("Access not acknowledged");

   a_ack_only: assert property (@(posedge ref_clk) disable iff (!resetn)
      !ps_req.valid |=> !ps_ack)
      else $error("Acknowledge without access");

   a_rdata_hold: assert property (@(posedge ref_clk) disable iff (!resetn)
      !(ps_req.valid && !ps_req.write) |=> $stable(ps_rdata))
      else $error("Read data moved without read");

   a_read_sec: assert property (@(posedge ref_clk) disable iff (!resetn)
      ps_req.valid && !ps_req.write && ps_req.num == 8'h05 |=> ps_rdata == $past(sec_r))
      else $error("Security read wrong");

   a_read_osc_ctrl: assert property (@(posedge ref_clk) disable iff (!resetn)
      ps_req.valid && !ps_req.write && ps_req.num == 8'h06 |=> ps_rdata[31:2] == 30'h0)
      else $error("Oscillator control reserved bits set");

   a_read_ram_value: assert property (@(posedge ref_clk) disable iff (!resetn)
      ps_req.valid && !ps_req.write && ps_req.num == 8'h0c |=> ps_rdata == (RAM_BYTES & 32'hffff_fffc))
      else $error("RAM size value wrong");

   a_read_unmapped: assert property (@(posedge ref_clk) disable iff (!resetn)
      ps_req.valid && !ps_req.write && ps_req.num == 8'h0b |=> ps_rdata == 32'h0)
      else $error("Unmapped read not zero");

   a_read_wire_hi: assert property (@(posedge ref_clk) disable iff (!resetn)
      ps_req.valid && !ps_req.write && ps_req.num == 8'h08 |=> ps_rdata[31:16] == 16'h0)
      else $error("Core wire upper bits not zero");

   a_read_pcell_hi: assert property (@(posedge ref_clk) disable iff (!resetn)
      ps_req.valid && !ps_req.write && ps_req.num == 8'h09 |=> ps_rdata[31:16] == 16'h0)
      else $error("Peripheral cell upper bits not zero");

   a_read_pwire_hi: assert property (@(posedge ref_clk) disable iff (!resetn)
      ps_req.valid && !ps_req.write && ps_req.num == 8'h0a |=> ps_rdata[31:16] == 16'h0)
      else $error("Peripheral wire upper bits not zero");

   a_read_ssr: assert property (@(posedge ref_clk) disable iff (!resetn)
      ps_req.valid && !ps_req.write && ps_req.num == 8'h10 |=> ps_rdata == $past(ssr_r))
      else $error("Saved status read wrong");

   a_ssr_hold: assert property (@(posedge ref_clk) disable iff (!resetn)
      !debug_enter && !wr_ssr |=> $stable(ssr_r))
      else $error("Saved status changed unprompted");

   a_ssr_dual_ro: assert property (@(posedge ref_clk) disable iff (!resetn)
      wr_ssr && !debug_enter |=> ssr_r[8] == $past(ssr_r[8]))
      else $error("Read-only dual issue bit written");

   a_ssr_write_take: assert property (@(posedge ref_clk) disable iff (!resetn)
      wr_ssr && !debug_enter |=> ssr_r[10:9] == $past(ps_req.wdata[10:9]) && ssr_r[7:6] == $past(ps_req.wdata[7:6]))
      else $error("Saved status write not taken");

   a_ssr_dual_cap: assert property (@(posedge ref_clk) disable iff (!resetn)
      debug_enter |=> ssr_r[8] == $past(thread_status.dual_issue_active))
      else $error("Dual issue not captured");

   a_ssr_kernel_cap: assert property (@(posedge ref_clk) disable iff (!resetn)
      debug_enter |=> ssr_r[4] == $past(thread_status.kernel_mode_flag))
      else $error("Kernel mode not captured");

   c_osc_both_run: cover property (@(posedge ref_clk) disable iff (!resetn) core_osc_enable && periph_osc_enable);
   c_ssr_written: cover property (@(posedge ref_clk) disable iff (!resetn) wr_ssr);
   c_sec_locked_write: cover property (@(posedge ref_clk) disable iff (!resetn) ps_write_refused);
   c_debug_capture: cover property (@(posedge ref_clk) disable iff (!resetn) debug_enter);
   c_osc_stopped: cover property (@(posedge ref_clk) disable iff (!resetn) $rose(osc_stable));

endmodule // tsr_bank

// ### design/tsr_cfg.svh
// Constants for the tile security, ring oscillator and status register bank
// Functional notes
// - Security configuration loads from the security word read out of OTP.
// - Bit 31 set locks the security configuration against further writes.
// - Bit 14 set blocks the tile's global debug facility.
// - Bit 9 set blocks all OTP read access.
// - Bit 8 set blocks the OTP programming serial port.
// - Bit 7 set merges OTP into one read address space.
// - Bit 5 set forces boot from OTP, overriding boot mode.
// - Bit 4 set blocks JTAG access to PLL and boot config.
// - Bit 0 set blocks the tile's JTAG debug TAP.
// - Four free-running oscillators each clock a counter; control register starts/stops them.
// - Control bit 1 enables core oscillators; resets to zero.
// - Control bit 0 enables peripheral oscillators; resets to zero.
// - Oscillators run asynchronously to the tile clock as a random source.
// - Counters readable at 0x07, 0x08, 0x09 and 0x0a.
// - Counter registers hold 16-bit count in bits 15:0, upper bits reserved.
// - Oscillator counters are not cleared by system reset.
// - Register 0x0c reports RAM size in bytes in bits 31:2.
// - Debugger entry captures the thread status word into register 0x10.
// - Status bits 10 high priority, 9 kernel dual issue, 8 dual issue read-only.
// - Status bits 7 fast issue, 6 paused; bit 5 reserved.
// - Status bits 4 kernel, 3 handler, 2 enabling, 1 interrupts, 0 events.
// - Registers reached only by status read and write operations by number.
`ifndef TSR_CFG_SVH
`define TSR_CFG_SVH

`define TSR_ADDR_SECURITY      8'h05
`define TSR_ADDR_OSC_CTRL      8'h06
`define TSR_ADDR_CORE_CELL     8'h07
`define TSR_ADDR_CORE_WIRE     8'h08
`define TSR_ADDR_PERI_CELL     8'h09
`define TSR_ADDR_PERI_WIRE     8'h0a
`define TSR_ADDR_RAM_SIZE      8'h0c
`define TSR_ADDR_SAVED_STATUS  8'h10

`define TSR_SEC_WRITE_MASK     32'h8000_47b1
`define TSR_SEC_LOCK_BIT       31
`define TSR_SEC_NO_GDEBUG_BIT  14
`define TSR_SEC_OTP_RDLOCK_BIT 9
`define TSR_SEC_OTP_PROG_BIT   8
`define TSR_SEC_OTP_MERGE_BIT  7
`define TSR_SEC_OTP_BOOT_BIT   5
`define TSR_SEC_PLL_JTAG_BIT   4
`define TSR_SEC_JTAG_TAP_BIT   0

`define TSR_OSC_CORE_BIT       1
`define TSR_OSC_PERI_BIT       0
`define TSR_OSC_CTRL_RESET     2'h0

`define TSR_SSR_MASK           32'h0000_07df
`define TSR_SSR_WRITE_MASK     32'h0000_06df
`define TSR_SSR_DUAL_BIT       8
`define TSR_RAM_SIZE_MASK      32'hffff_fffc

`define TSR_OSC_STOP_CYCLES    10

`endif

// ### design/tsr_pkg.sv
// Types for the tile security, ring oscillator and status register bank
package tsr_pkg;

   typedef struct packed {
      logic        valid;
      logic        write;
      logic [7:0]  num;
      logic [31:0] wdata;
   } tsr_req_s;

   typedef struct packed {
      logic no_global_debug;
      logic otp_read_lock;
      logic otp_program_block;
      logic otp_merge_space;
      logic boot_from_otp_override;
      logic pll_jtag_block;
      logic jtag_tap_block;
   } tsr_sec_s;

   typedef struct packed {
      logic high_priority_flag;
      logic kernel_entry_dual_issue;
      logic dual_issue_active;
      logic fast_issue_flag;
      logic thread_paused_flag;
      logic kernel_mode_flag;
      logic in_handler_flag;
      logic in_event_enable_seq;
      logic interrupts_enabled_flag;
      logic events_enabled_flag;
   } tsr_status_s;

   typedef enum logic [1:0] {
      TSR_LOAD_IDLE,
      TSR_LOAD_DONE
   } tsr_load_e;

endpackage

// ### dv/tile_security_ringosc_status_regs_tb_top.sv
// Self-checking bench for the security, oscillator and status register bank
`timescale 1ns/10ps

module tile_security_ringosc_status_regs_tb_top;
   logic                 ref_clk;
   logic                 resetn;
   tsr_pkg::tsr_req_s    req;
   logic [31:0]          ps_rdata;
   logic                 ps_ack;
   logic                 ps_write_refused;
   logic                 otp_v;
   logic [31:0]          otp_w;
   logic                 dbg;
   tsr_pkg::tsr_status_s st;
   logic [3:0]           osc;
   logic                 osc_0 = 1'b0;
   logic                 osc_1 = 1'b0;
   logic                 osc_2 = 1'b0;
   logic                 osc_3 = 1'b0;
   logic                 core_en;
   logic                 peri_en;
   tsr_pkg::tsr_sec_s    sec;
   logic                 osc_stable;
   logic [31:0]          rd;
   logic [31:0]          keep;
   logic                 refused;
   int                   num_errors;
   int                   check_count;
   int                   pos [7] = '{14, 9, 8, 7, 5, 4, 0};

   tsr_bank DUT (
      .ref_clk           (ref_clk),
      .resetn            (resetn),
      .ps_req            (req),
      .ps_rdata          (ps_rdata),
      .ps_ack            (ps_ack),
      .ps_write_refused  (ps_write_refused),
      .otp_word_valid    (otp_v),
      .otp_security_word (otp_w),
      .debug_enter       (dbg),
      .thread_status     (st),
      .osc_clk           (osc),
      .core_osc_enable   (core_en),
      .periph_osc_enable (peri_en),
      .sec_ctrl          (sec),
      .osc_stable        (osc_stable)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Clocks
   initial begin
      ref_clk = 1'b0;
      forever #50 ref_clk = ~ref_clk;
   end
   always #19 osc_0 = ~osc_0;
   always #23 osc_1 = ~osc_1;
   always #29 osc_2 = ~osc_2;
   always #31 osc_3 = ~osc_3;
   assign osc = {osc_3, osc_2, osc_1, osc_0};

   ////////////////////////////////////////////////////////////////////////////
   // Tasks
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         num_errors++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic acc(input logic wr, input logic [7:0] n, input logic [31:0] d);
      @(negedge ref_clk);
      req = '{valid: 1'b1, write: wr, num: n, wdata: d};
      #40 refused = ps_write_refused;
      @(negedge ref_clk);
      req.valid = 1'b0;
      chk({31'h0, ps_ack}, 32'h1);
      rd = ps_rdata;
   endtask

   task automatic rchk(input logic [7:0] n, input logic [31:0] e);
      acc(1'b0, n, 32'h0);
      chk(rd, e);
   endtask

   task automatic otp(input logic [31:0] w);
      @(negedge ref_clk);
      otp_v = 1'b1;
      otp_w = w;
      @(negedge ref_clk);
      otp_v = 1'b0;
   endtask

   task automatic dent(input logic [9:0] s);
      @(negedge ref_clk);
      st = tsr_pkg::tsr_status_s'(s);
      dbg = 1'b1;
      @(negedge ref_clk);
      dbg = 1'b0;
   endtask

   task automatic rst;
      @(negedge ref_clk);
      resetn = 1'b0;
      repeat (20) @(negedge ref_clk);
      resetn = 1'b1;
   endtask

   task automatic close_out;
      if (num_errors == 0 && check_count > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////////
   // Watchdog
   initial begin
      #(5000 * 100);
      num_errors++;
      close_out();
   end

   ////////////////////////////////////////////////////////////////////////////
   // Tests
   initial begin
      resetn = 1'b0;
      req = '0;
      otp_v = 1'b0;
      otp_w = '0;
      dbg = 1'b0;
      st = '0;
      num_errors = 0;
      check_count = 0;
      rst();
      chk({30'h0, core_en, peri_en}, 32'h0);
      rchk(8'h06, 32'h0);
      otp(32'h7fff_ffff);
      rchk(8'h05, 32'h0000_47b1);
      chk({25'h0, sec}, 32'h7f);
      otp(32'h0);
      rchk(8'h05, 32'h0000_47b1);
      for (int i = 0; i < 7; i++) begin
         acc(1'b1, 8'h05, 32'h1 << pos[i]);
         chk({31'h0, refused}, 32'h0);
         chk({25'h0, sec}, 32'h40 >> i);
      end
      acc(1'b1, 8'h05, 32'h8000_0011);
      acc(1'b1, 8'h05, 32'h0);
      chk({31'h0, refused}, 32'h1);
      rchk(8'h05, 32'h8000_0011);
      chk({25'h0, sec}, 32'h03);
      // Oscillator enables and stop delay
      acc(1'b1, 8'h06, 32'h2);
      chk({30'h0, core_en, peri_en}, 32'h2);
      acc(1'b1, 8'h06, 32'h1);
      chk({30'h0, core_en, peri_en}, 32'h1);
      acc(1'b1, 8'h06, 32'hffff_ffff);
      rchk(8'h06, 32'h3);
      repeat (20) @(negedge ref_clk);
      chk({31'h0, osc_stable}, 32'h0);
      acc(1'b1, 8'h06, 32'h0);
      repeat (7) @(negedge ref_clk);
      chk({31'h0, osc_stable}, 32'h0);
      repeat (5) @(negedge ref_clk);
      chk({31'h0, osc_stable}, 32'h1);
      for (int i = 7; i < 11; i++) begin
         acc(1'b0, 8'(i), 32'h0);
         chk(rd & 32'hffff_0000, 32'h0);
         chk({31'h0, rd != 32'h0}, 32'h1);
      end
      acc(1'b0, 8'h07, 32'h0);
      keep = rd;
      rchk(8'h07, keep);
      // Reset in mid-run
      rst();
      rchk(8'h07, keep);
      chk({25'h0, sec}, 32'h0);
      rchk(8'h06, 32'h0);
      otp(32'h8000_0020);
      chk({25'h0, sec}, 32'h04);
      acc(1'b1, 8'h05, 32'h0);
      chk({31'h0, refused}, 32'h1);
      rchk(8'h05, 32'h8000_0020);
      // RAM size and unmapped place
      rchk(8'h0c, 32'h0010_0000);
      acc(1'b1, 8'h0c, 32'h0);
      rchk(8'h0c, 32'h0010_0000);
      acc(1'b1, 8'h0b, 32'hffff_ffff);
      rchk(8'h0b, 32'h0);
      // Saved status capture
      dent(10'h3ff);
      rchk(8'h10, 32'h0000_07df);
      dent(10'h155);
      rchk(8'h10, 32'h0000_0295);
      acc(1'b1, 8'h10, 32'hffff_ffff);
      rchk(8'h10, 32'h0000_06df);
      dent(10'h2aa);
      rchk(8'h10, 32'h0000_054a);
      acc(1'b1, 8'h10, 32'h0);
      rchk(8'h10, 32'h0000_0100);
      close_out();
   end
endmodule // tile_security_ringosc_status_regs_tb_top
